// ---- core/lpdt_buf2.sv ----
// Purpose: two-entry buffer in the column data path
// Assumes: single clock, synchronous active-high reset
// Notes:   in_ready_o is registered so a stall never drops a word
`timescale 1ns/1ps
module lpdt_buf2 (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [lpdt_pkg::DATA_W-1:0]   in_data_i,
  input  wire logic                          in_valid_i,
  output logic                               in_ready_o,
  output logic [lpdt_pkg::DATA_W-1:0]        out_data_o,
  output logic                               out_valid_o,
  input  wire logic                          out_ready_i
);
  logic [lpdt_pkg::DATA_W-1:0] mem_ff [lpdt_pkg::BUF_DEPTH];
  logic                        wr_ptr_ff;
  logic                        rd_ptr_ff;
  logic [1:0]                  cnt_ff;
  logic [1:0]                  nxt_cnt;
  logic                        ready_ff;
  logic                        push;
  logic                        pop;

  assign push        = in_valid_i && ready_ff;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign in_ready_o  = ready_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= 2'h0;
      ready_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      ready_ff <= (nxt_cnt != 2'(lpdt_pkg::BUF_DEPTH));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  AST_BUF_FULL_REFUSES : assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_ff == 2'h2) |-> !in_ready_o)
    else $error("buffer full but still ready");

endmodule // lpdt_buf2

// ---- core/lpdt_pkg.sv ----
// Purpose: shared constants and types for the lcd panel drive timing block
// Assumes: panel-side logic runs on the panel clock lclk_i
// Notes:   column data is one 4-bit nibble per column shift period
package lpdt_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int          DATA_W       = 4;
  localparam int          BUF_DEPTH    = 2;
  localparam int          PH_W         = 5;
  localparam logic        DRV_OFF_RST  = 1'b0;
  localparam logic [3:0]  DATA_RST     = 4'h0;

  // ==========================================================================
  // column shift ratio straps and the divide they select
  localparam logic [1:0]  STRAP_DIV4   = 2'h0;
  localparam logic [1:0]  STRAP_DIV8   = 2'h1;
  localparam logic [1:0]  STRAP_DIV16  = 2'h2;
  localparam logic [4:0]  DIV4_CYC     = 5'h04;
  localparam logic [4:0]  DIV8_CYC     = 5'h08;
  localparam logic [4:0]  DIV16_CYC    = 5'h10;

  // frames counted after power save before the drive goes off
  localparam logic [1:0]  PS_FRAMES    = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    LPDT_OFF   = 2'b00,
    LPDT_DATA  = 2'b01,
    LPDT_LATCH = 2'b10
  } lpdt_state_t;

  typedef struct packed {
    logic [7:0] words_m1;
    logic [8:0] lines_m1;
    logic [7:0] bias_lines_m1;
  } lpdt_geom_t;

  typedef struct packed {
    logic [3:0] column_pixel_data;
    logic       column_shift_clock;
    logic       column_enable_chain_clock;
    logic       line_latch_pulse;
    logic       backplane_bias_toggle;
    logic       row_shift_clock;
    logic       row_scan_pulse;
    logic       display_drive_off;
  } lpdt_panel_t;

endpackage

// ---- core/lpdt_top.sv ----
// Purpose: drive timing for lcd column and row driver chips
// Assumes: geom_i is static or changed on the panel clock; straps and
//          power_save_i are asynchronous to lclk_i
// Notes:   a word not delivered in time shows as the previous nibble
// Notes on behaviour
// - column pixel data leaves on a 4-bit parallel bus.
// - column drivers capture the data on each falling column shift edge.
// - the column shift clock idles from the line latch to the next line.
// - the enable chain clock falls once per column word to step the cascade.
// - exactly one line latch pulse per line, acting on its falling edge.
// - the backplane bias toggles with a period set by a setup parameter.
// - the row shift clock falling edge loads the row scan level.
// - the row scan pulse is high only during the last line of a frame.
// - display drive off is high while the drive outputs are active.
// - after power save, display drive off falls within one to two frames.
// - the column shift period is 4, 8 or 16 clocks chosen by the straps.
`timescale 1ns/1ps
module lpdt_top (
  input  wire logic                         mclk_i,
  input  wire logic                         rst_i,
  input  wire logic [lpdt_pkg::DATA_W-1:0]  pix_data_i,
  input  wire logic                         pix_valid_i,
  output logic                              pix_ready_o,
  input  wire logic                         power_save_i,
  input  wire logic                         lclk_i,
  input  wire lpdt_pkg::lpdt_geom_t         geom_i,
  input  wire logic [1:0]                   shift_ratio_straps_i,
  output lpdt_pkg::lpdt_panel_t             panel_o
);

  // ==========================================================================
  // functions
  function automatic logic [4:0] div_of(input logic [1:0] straps);
    unique case (straps)
      lpdt_pkg::STRAP_DIV4:  div_of = lpdt_pkg::DIV4_CYC;
      lpdt_pkg::STRAP_DIV8:  div_of = lpdt_pkg::DIV8_CYC;
      lpdt_pkg::STRAP_DIV16: div_of = lpdt_pkg::DIV16_CYC;
      // reserved setting falls back to the slowest, safest rate
      default:               div_of = lpdt_pkg::DIV16_CYC;
    endcase
  endfunction

  // ==========================================================================
  // system clock side: buffer and word handshake
  logic [lpdt_pkg::DATA_W-1:0] buf_data;
  logic                        buf_valid;
  logic                        buf_ready;
  logic [lpdt_pkg::DATA_W-1:0] word_ff;
  logic                        req_ff;
  logic                        busy_ff;
  logic                        ack_s1_ff;
  logic                        ack_s2_ff;
  logic                        ack_ff;

  lpdt_buf2 u_buf (
    .clk_i       (mclk_i),
    .rst_i       (rst_i),
    .in_data_i   (pix_data_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready)
  );

  assign buf_ready = !busy_ff;

  // word_ff is held until the link side acknowledges, so it may cross
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word_ff <= lpdt_pkg::DATA_RST;
      req_ff  <= 1'b0;
      busy_ff <= 1'b0;
    end else if (!busy_ff && buf_valid) begin
      word_ff <= buf_data;
      req_ff  <= ~req_ff;
      busy_ff <= 1'b1;
    end else if (busy_ff && (ack_s2_ff == req_ff)) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ==========================================================================
  // panel clock side: reset and input synchronisers
  logic       lrst_s1_ff;
  logic       lrst_ff;
  logic       req_s1_ff;
  logic       req_s2_ff;
  logic       ps_s1_ff;
  logic       ps_s2_ff;
  logic [1:0] strap_s1_ff;
  logic [1:0] strap_s2_ff;

  always_ff @(posedge lclk_i) begin
    lrst_s1_ff <= rst_i;
    lrst_ff    <= lrst_s1_ff;
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      req_s1_ff   <= 1'b0;
      req_s2_ff   <= 1'b0;
      ps_s1_ff    <= 1'b0;
      ps_s2_ff    <= 1'b0;
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
    end else begin
      req_s1_ff   <= req_ff;
      req_s2_ff   <= req_s1_ff;
      ps_s1_ff    <= power_save_i;
      ps_s2_ff    <= ps_s1_ff;
      strap_s1_ff <= shift_ratio_straps_i;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ==========================================================================
  // panel clock side: sequencer
  lpdt_pkg::lpdt_state_t state_ff;
  lpdt_pkg::lpdt_state_t nxt_state;
  logic [lpdt_pkg::PH_W-1:0] ph_ff;
  logic [lpdt_pkg::PH_W-1:0] nxt_ph;
  logic [4:0]                ratio_ff;
  logic [4:0]                nxt_ratio;
  logic [4:0]                nxt_half;
  logic [7:0]                word_cnt_ff;
  logic [7:0]                nxt_word;
  logic [8:0]                line_ff;
  logic [8:0]                nxt_line;
  logic                      line_end;
  logic                      frame_end;
  logic                      line_start;
  logic                      load;
  logic [1:0]                ps_frames_ff;

  always_comb begin
    nxt_state  = state_ff;
    nxt_ph     = ph_ff;
    nxt_word   = word_cnt_ff;
    nxt_line   = line_ff;
    line_end   = 1'b0;
    frame_end  = 1'b0;
    line_start = 1'b0;
    unique case (state_ff)
      lpdt_pkg::LPDT_OFF: begin
        if (!ps_s2_ff) begin
          nxt_state  = lpdt_pkg::LPDT_DATA;
          nxt_ph     = '0;
          nxt_word   = 8'h00;
          nxt_line   = 9'h000;
          line_start = 1'b1;
        end
      end
      lpdt_pkg::LPDT_DATA: begin
        if (ph_ff == ratio_ff - 5'h01) begin
          nxt_ph = '0;
          if (word_cnt_ff == geom_i.words_m1) begin
            nxt_word  = 8'h00;
            nxt_state = lpdt_pkg::LPDT_LATCH;
          end else begin
            nxt_word = word_cnt_ff + 8'h01;
          end
        end else begin
          nxt_ph = ph_ff + 5'h01;
        end
      end
      lpdt_pkg::LPDT_LATCH: begin
        if (ph_ff == ratio_ff - 5'h01) begin
          nxt_ph   = '0;
          line_end = 1'b1;
          if (line_ff == geom_i.lines_m1) begin
            frame_end = 1'b1;
            nxt_line  = 9'h000;
            // second frame boundary after power save stops the drive
            if (ps_s2_ff && ps_frames_ff == lpdt_pkg::PS_FRAMES - 2'h1) begin
              nxt_state = lpdt_pkg::LPDT_OFF;
            end else begin
              nxt_state  = lpdt_pkg::LPDT_DATA;
              line_start = 1'b1;
            end
          end else begin
            nxt_line   = line_ff + 9'h001;
            nxt_state  = lpdt_pkg::LPDT_DATA;
            line_start = 1'b1;
          end
        end else begin
          nxt_ph = ph_ff + 5'h01;
        end
      end
      default: nxt_state = lpdt_pkg::LPDT_OFF;
    endcase
  end

  // ratio is sampled only at a line start so a strap change never
  // truncates a shift period
  assign nxt_ratio = line_start ? div_of(strap_s2_ff) : ratio_ff;
  assign nxt_half  = nxt_ratio >> 1;
  assign load      = (nxt_state == lpdt_pkg::LPDT_DATA) && (nxt_ph == '0);

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      state_ff    <= lpdt_pkg::LPDT_OFF;
      ph_ff       <= '0;
      word_cnt_ff <= 8'h00;
      line_ff     <= 9'h000;
      ratio_ff    <= lpdt_pkg::DIV16_CYC;
    end else begin
      state_ff    <= nxt_state;
      ph_ff       <= nxt_ph;
      word_cnt_ff <= nxt_word;
      line_ff     <= nxt_line;
      ratio_ff    <= nxt_ratio;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff || !ps_s2_ff) begin
      ps_frames_ff <= 2'h0;
    end else if (frame_end && ps_frames_ff != lpdt_pkg::PS_FRAMES) begin
      ps_frames_ff <= ps_frames_ff + 2'h1;
    end
  end

  // ==========================================================================
  // panel clock side: word hand-off from the system side
  logic [lpdt_pkg::DATA_W-1:0] held_ff;
  logic                        held_vld_ff;

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      held_ff     <= lpdt_pkg::DATA_RST;
      held_vld_ff <= 1'b0;
      ack_ff      <= 1'b0;
    end else if ((req_s2_ff != ack_ff) && (!held_vld_ff || load)) begin
      held_ff     <= word_ff;
      held_vld_ff <= 1'b1;
      ack_ff      <= req_s2_ff;
    end else if (load) begin
      held_vld_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // panel clock side: output registers
  logic [3:0] data_ff;
  logic       shift_ff;
  logic       ecl_ff;
  logic       latch_ff;
  logic       row_clk_ff;
  logic       row_scan_ff;
  logic       bias_ff;
  logic [7:0] bias_cnt_ff;
  logic       drv_on_ff;
  logic       bias_due;
  logic       data_hi;
  logic       latch_hi;

  // high halves of the data and latch periods, taken from the next phase
  assign data_hi  = (nxt_state == lpdt_pkg::LPDT_DATA) && (nxt_ph < nxt_half);
  assign latch_hi = (nxt_state == lpdt_pkg::LPDT_LATCH) && (nxt_ph < nxt_half);

  // data moves together with the rising shift edge
  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      data_ff <= lpdt_pkg::DATA_RST;
    end else if (load && held_vld_ff) begin
      data_ff <= held_ff;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      shift_ff <= 1'b0;
      ecl_ff   <= 1'b0;
    end else begin
      // low outside data periods, so it idles through the latch
      shift_ff <= data_hi;
      ecl_ff   <= data_hi;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      latch_ff   <= 1'b0;
      row_clk_ff <= 1'b0;
    end else begin
      latch_ff   <= latch_hi;
      row_clk_ff <= latch_hi;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      row_scan_ff <= 1'b0;
    end else begin
      row_scan_ff <= (nxt_state != lpdt_pkg::LPDT_OFF)
                     && (nxt_line == geom_i.lines_m1);
    end
  end

  assign bias_due = line_end && (bias_cnt_ff == geom_i.bias_lines_m1);

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      bias_ff     <= 1'b0;
      bias_cnt_ff <= 8'h00;
    end else if (bias_due) begin
      bias_ff     <= ~bias_ff;
      bias_cnt_ff <= 8'h00;
    end else if (line_end) begin
      bias_cnt_ff <= bias_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst_ff) begin
      drv_on_ff <= lpdt_pkg::DRV_OFF_RST;
    end else begin
      drv_on_ff <= (nxt_state != lpdt_pkg::LPDT_OFF);
    end
  end

  assign panel_o.column_pixel_data         = data_ff;
  assign panel_o.column_shift_clock        = shift_ff;
  assign panel_o.column_enable_chain_clock = ecl_ff;
  assign panel_o.line_latch_pulse          = latch_ff;
  assign panel_o.backplane_bias_toggle     = bias_ff;
  assign panel_o.row_shift_clock           = row_clk_ff;
  assign panel_o.row_scan_pulse            = row_scan_ff;
  assign panel_o.display_drive_off         = drv_on_ff;

  // ==========================================================================
  // checks
  logic [4:0] hi_len_ff;

  always_ff @(posedge lclk_i) begin
    if (lrst_ff || !shift_ff) begin
      hi_len_ff <= 5'h00;
    end else begin
      hi_len_ff <= hi_len_ff + 5'h01;
    end
  end

  AST_DATA_WIDTH_STABLE : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $fell(shift_ff) |-> ##1 (!shift_ff && $stable(data_ff)))
    else $error("column data moved right after capture edge");

  AST_DATA_AT_FALL : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $fell(shift_ff) |-> $stable(data_ff))
    else $error("column data moved at shift falling edge");

  AST_SHIFT_IDLE_LATCH : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $rose(latch_ff) |-> !shift_ff [*2])
    else $error("column shift clock ran during line latch");

  AST_ECL_WITH_SHIFT : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $fell(ecl_ff) |-> $fell(shift_ff))
    else $error("enable chain clock fell off the column step");

  AST_ONE_LATCH_PER_LINE : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $rose(latch_ff) |-> $past(state_ff) == lpdt_pkg::LPDT_DATA)
    else $error("line latch not preceded by a data line");

  AST_BIAS_ON_COUNT : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $changed(bias_ff) |-> $past(bias_due))
    else $error("bias toggled without its line count");

  AST_ROW_CLK_LOADS_SCAN : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $fell(row_clk_ff) |-> $fell(latch_ff) && $stable(row_scan_ff))
    else $error("row scan level moved at row clock edge");

  AST_ROW_PULSE_LAST_LINE : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    row_scan_ff |-> line_ff == geom_i.lines_m1)
    else $error("row scan pulse outside last line");

  AST_DRIVE_FLAG_ACTIVE : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    (shift_ff || latch_ff) |-> drv_on_ff)
    else $error("drive outputs active with drive flag low");

  AST_OFF_AFTER_FRAMES : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    (ps_frames_ff == lpdt_pkg::PS_FRAMES) |-> !drv_on_ff)
    else $error("drive still on two frames after power save");

  AST_SHIFT_RATIO : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $fell(shift_ff) |-> hi_len_ff == (ratio_ff >> 1))
    else $error("column shift high time not half the ratio");

  AST_DATA_MOVES_HIGH : assert property (
    @(posedge lclk_i) disable iff (lrst_ff)
    $changed(data_ff) |-> shift_ff)
    else $error("column data changed while shift clock low");

endmodule // lpdt_top

// ---- verif/lpdt_drv_model.sv ----
// Purpose: behavioural column and row driver chips on the panel outputs
// Assumes: panel outputs settle on lclk edges
// Notes:   counts and orders what the drivers capture; no outputs
`timescale 1ns/1ps
module lpdt_drv_model (
  input  wire lpdt_pkg::lpdt_panel_t  panel_i
);
  logic [15:0] shift_ff      = 16'h0000;
  logic [15:0] ecl_ff        = 16'h0000;
  logic [15:0] sh_base_ff    = 16'h0000;
  logic [15:0] ecl_base_ff   = 16'h0000;
  logic [15:0] line_words_ff = 16'h0000;
  logic [15:0] line_ecl_ff   = 16'h0000;
  logic [15:0] latches_ff    = 16'h0000;
  logic [15:0] order_err_ff  = 16'h0000;
  logic [15:0] row_ones_ff   = 16'h0000;
  logic [15:0] frames_ff     = 16'h0000;
  logic [3:0]  last_nib_ff   = 4'h0;

  // ==========================================================================
  // column drivers
  // a dropped nibble shows as a jump of two; an underrun only repeats
  always @(negedge panel_i.column_shift_clock) begin
    shift_ff    <= shift_ff + 16'h0001;
    last_nib_ff <= panel_i.column_pixel_data;
    if (panel_i.column_pixel_data !== last_nib_ff &&
        panel_i.column_pixel_data !== last_nib_ff + 4'h1) begin
      order_err_ff <= order_err_ff + 16'h0001;
    end
  end

  always @(negedge panel_i.column_enable_chain_clock)
    ecl_ff <= ecl_ff + 16'h0001;

  always @(negedge panel_i.line_latch_pulse) begin
    latches_ff    <= latches_ff + 16'h0001;
    line_words_ff <= shift_ff - sh_base_ff;
    sh_base_ff    <= shift_ff;
    line_ecl_ff   <= ecl_ff - ecl_base_ff;
    ecl_base_ff   <= ecl_ff;
  end

  // ==========================================================================
  // row drivers
  always @(negedge panel_i.row_shift_clock) begin
    if (panel_i.row_scan_pulse === 1'b1) begin
      row_ones_ff <= row_ones_ff + 16'h0001;
    end
  end

  always @(negedge panel_i.row_scan_pulse)
    frames_ff <= frames_ff + 16'h0001;
endmodule // lpdt_drv_model

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the lcd panel drive timing block
// Assumes: geometry of 4 words, 4 lines, bias every 2 lines
// Notes:   reset held long enough to reach the panel clock domain
`timescale 1ns/1ps
module tb_top;
  localparam int LCLK_NS = 64;
  localparam int WORDS   = 4;
  localparam int LINES   = 4;
  localparam int BIAS_L  = 2;

  logic                  mclk_i;
  logic                  lclk_i;
  logic                  rst_i;
  logic [3:0]            pix_data_i;
  logic                  pix_valid_i;
  logic                  pix_ready_o;
  logic                  power_save_i;
  logic [1:0]            straps;
  lpdt_pkg::lpdt_geom_t  geom;
  lpdt_pkg::lpdt_panel_t panel;
  logic [3:0]            prev_dat;
  logic                  saw_full;
  int                    n_mismatch;
  int                    comparisons;

  lpdt_top i_lpdt_top (
    .mclk_i               (mclk_i),
    .rst_i                (rst_i),
    .pix_data_i           (pix_data_i),
    .pix_valid_i          (pix_valid_i),
    .pix_ready_o          (pix_ready_o),
    .power_save_i         (power_save_i),
    .lclk_i               (lclk_i),
    .geom_i               (geom),
    .shift_ratio_straps_i (straps),
    .panel_o              (panel)
  );

  lpdt_drv_model i_lpdt_drv_model (
    .panel_i (panel)
  );

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    lclk_i = 1'b0;
    #7;
    forever #32 lclk_i = ~lclk_i;
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // straps are only taken at a line start, so let two lines pass
  task automatic set_ratio(input logic [1:0] s);
    @(negedge mclk_i);
    straps = s;
    repeat (2) @(negedge panel.line_latch_pulse);
  endtask

  task automatic feed(input int n);
    for (int i = 1; i <= n; i++) begin
      @(negedge mclk_i);
      pix_valid_i = 1'b1;
      pix_data_i  = 4'(i);
      // ready only moves on a rising edge, so the falling edge shows it
      while (pix_ready_o !== 1'b1) begin
        saw_full = 1'b1;
        @(negedge mclk_i);
      end
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    pix_valid_i = 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_stream();
    logic [15:0] e0;
    set_ratio(lpdt_pkg::STRAP_DIV16);
    e0 = i_lpdt_drv_model.order_err_ff;
    feed(24);
    check(saw_full, 1'b1);
    repeat (4) @(negedge panel.line_latch_pulse);
    #1;
    check(i_lpdt_drv_model.order_err_ff - e0, 0);
    check(panel.column_pixel_data, 4'h8);
    check(i_lpdt_drv_model.line_words_ff, WORDS);
    check(i_lpdt_drv_model.line_ecl_ff, WORDS);
    check(panel.display_drive_off, 1'b1);
  endtask

  task automatic t_ratio();
    time t0;
    int  h;
    for (int s = 0; s < 4; s++) begin
      h = (s == 0) ? 2 : ((s == 1) ? 4 : 8);
      set_ratio(2'(s));
      @(posedge panel.column_shift_clock);
      t0 = $time;
      @(negedge panel.column_shift_clock);
      check(32'(($time - t0) / LCLK_NS), h);
      @(posedge panel.line_latch_pulse);
      t0 = $time;
      check(panel.column_shift_clock, 1'b0);
      @(negedge panel.line_latch_pulse);
      check(32'(($time - t0) / LCLK_NS), h);
    end
  endtask

  task automatic t_row_bias();
    time         t0;
    logic [15:0] l0;
    logic [15:0] r0;
    set_ratio(lpdt_pkg::STRAP_DIV4);
    @(posedge panel.row_scan_pulse);
    t0 = $time;
    l0 = i_lpdt_drv_model.latches_ff;
    r0 = i_lpdt_drv_model.row_ones_ff;
    @(negedge panel.row_scan_pulse);
    check(32'(($time - t0) / LCLK_NS), (WORDS + 1) * 4);
    @(posedge panel.row_scan_pulse);
    check(i_lpdt_drv_model.latches_ff - l0, LINES);
    check(i_lpdt_drv_model.row_ones_ff - r0, 1);
    @(panel.backplane_bias_toggle);
    t0 = $time;
    @(panel.backplane_bias_toggle);
    check(32'(($time - t0) / LCLK_NS), BIAS_L * (WORDS + 1) * 4);
  endtask

  task automatic t_psave();
    logic [15:0] f0;
    logic [15:0] s0;
    @(negedge panel.row_scan_pulse);
    #1;
    f0 = i_lpdt_drv_model.frames_ff;
    @(negedge mclk_i);
    power_save_i = 1'b1;
    @(negedge panel.display_drive_off);
    #1;
    f0 = i_lpdt_drv_model.frames_ff - f0;
    check((f0 >= 16'h0001) && (f0 <= 16'h0002), 1'b1);
    s0 = i_lpdt_drv_model.shift_ff;
    repeat (100) @(posedge lclk_i);
    check(i_lpdt_drv_model.shift_ff - s0, 0);
    @(negedge mclk_i);
    power_save_i = 1'b0;
    @(negedge panel.column_shift_clock);
    check(panel.display_drive_off, 1'b1);
  endtask

  // data may only move at a rising shift edge
  always @(negedge lclk_i) begin
    if (!rst_i && prev_dat !== panel.column_pixel_data)
      check(panel.column_shift_clock, 1'b1);
    prev_dat <= panel.column_pixel_data;
  end

  initial begin
    #2_000_000;
    n_mismatch++;
    results();
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst_i        = 1'b1;
    pix_data_i   = 4'h0;
    pix_valid_i  = 1'b0;
    power_save_i = 1'b0;
    straps       = lpdt_pkg::STRAP_DIV4;
    geom         = '{words_m1: 8'h03, lines_m1: 9'h003, bias_lines_m1: 8'h01};
    saw_full     = 1'b0;
    n_mismatch   = 0;
    comparisons  = 0;
    // the panel domain needs three lclk edges of reset
    repeat (14) @(negedge mclk_i);
    check(32'(panel), 0);
    check(pix_ready_o, 1'b0);
    rst_i = 1'b0;
    t_stream();
    t_ratio();
    t_row_bias();
    t_psave();
    results();
  end
endmodule // tb_top
